// [tcs_status_outputs.sv]
`timescale 1ns/10ps
`include "tcs_defs.svh"

// What this block does
// - Both CC terminations are off while reset is held.
// - Attach output pulls low once a source connection is valid.
// - Attach output also pulls low for a debug accessory.
// - High current flag pulls low only for a 3.0 A source.
// - Medium current flag pulls low only for a 1.5 A source.
// - Aux output function picked by a two-bit setting, default sink power.
// - Software mode: bit 0 at 2Dh set pulls aux low; resets to 0.
// - Fault mode: aux pulls low while a hardware fault is present.
// - Debug mode: aux pulls low while a debug accessory is present.
// - Sink power mode: aux pulls low only for a 3.0 A source.
// - Orientation released for CC1, pulled low for CC2.
// - System and receptacle discharge switch on and off together.
// - Discharge starts on detach or error recovery, for a set duration.
// - Power path enable pulls low with source attached and conditions met.
// - Power path released on detach, error recovery or VBUS out of window.
// - Error recovery drops power path, flags and CC terminations.
// - Detach during error recovery discharges for the fixed overvoltage time.
module tcs_status_outputs #(
	parameter int         TICK_CYCLES = `TCS_DRAIN_TICK_CYCLES,
	parameter logic [3:0] OV_TICKS    = `TCS_OV_DRAIN_TICKS
) (
	input  wire logic                SYS_CLK,
	input  wire logic                RESET,
	input  wire tcs_pkg::tcs_status_s STATUS,
	input  wire tcs_pkg::tcs_nvm_s   NVM_CFG,
	input  wire logic                VBUS_ABOVE_LOW,
	input  wire logic                VBUS_ABOVE_HIGH,
	input  wire logic                HW_FAULT,
	input  wire logic [7:0]          REG_ADDR,
	input  wire logic                REG_WR,
	input  wire logic [7:0]          REG_WDATA,
	output logic [7:0]               REG_RDATA,
	output logic                     CC1_TERM_EN,
	output logic                     CC2_TERM_EN,
	output logic                     ATTACH_PULL,
	output logic                     HIGH_CURRENT_FLAG_N_PULL,
	output logic                     MEDIUM_CURRENT_FLAG_N_PULL,
	output logic                     AUX_OUT_PULL,
	output logic                     ORIENT_PULL,
	output logic                     POWER_PATH_ENABLE_N_PULL,
	output logic                     SYSTEM_DISCHARGE_N_PULL,
	output logic                     RECEPTACLE_SENSE_DISCHARGE_EN
);
	// ============================================================
	// Synchronisers for the analog comparators and fault detectors.
	logic [2:0] meta_r;
	logic [2:0] sync_r;
	always_ff @(posedge SYS_CLK) begin
		meta_r <= {HW_FAULT, VBUS_ABOVE_HIGH, VBUS_ABOVE_LOW};
		sync_r <= meta_r;
	end
	wire vbus_low_ok  = sync_r[0];
	wire vbus_high_ov = sync_r[1];
	wire hw_fault     = sync_r[2];

	// ============================================================
	// Software control register.
	logic [7:0] aux_out_software_r;
	logic [7:0] rdata_r;
	wire        sel_sw = (REG_ADDR == `TCS_REG_GPIO_SW);
	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			aux_out_software_r <= `TCS_GPIO_SW_RST;
			rdata_r            <= 8'h00;
		end else begin
			if (REG_WR && sel_sw) begin
				aux_out_software_r <= REG_WDATA;
			end
			rdata_r <= sel_sw ? aux_out_software_r : 8'h00;
		end
	end

	// ============================================================
	// Output decode. Error recovery overrides every attached indication except the aux output in debug mode.
	wire err       = STATUS.err_recovery;
	wire src_ok    = STATUS.src_attached && !err;
	wire flag_3a   = src_ok && STATUS.adv_3a;
	wire flag_1a5  = src_ok && STATUS.adv_1a5;
	wire attach    = (STATUS.src_attached || STATUS.debug_attached) && !err;
	wire vbus_ok   = vbus_low_ok && !vbus_high_ov;
	wire pp_nxt    = src_ok && vbus_ok;
	wire fault_ind = hw_fault || err;
	logic aux_nxt;

	// Mode selection of the general-purpose output.
	always_comb begin
		unique case (NVM_CFG.gpio_cfg)
			tcs_pkg::TCS_GPIO_SOFTWARE:   aux_nxt = aux_out_software_r[`TCS_GPIO_SW_BIT];
			tcs_pkg::TCS_GPIO_FAULT:      aux_nxt = fault_ind;
			tcs_pkg::TCS_GPIO_DEBUG:      aux_nxt = STATUS.debug_attached;
			tcs_pkg::TCS_GPIO_SINK_POWER: aux_nxt = flag_3a;
		endcase
	end

	// ============================================================
	// Output flops; all pull-low enables are released under reset.
	logic cc_r, attach_r, f3_r, f15_r, aux_r, orient_r, pp_r, err_d_r;
	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			cc_r     <= 1'b0;
			attach_r <= 1'b0;
			f3_r     <= 1'b0;
			f15_r    <= 1'b0;
			aux_r    <= 1'b0;
			orient_r <= 1'b0;
			pp_r     <= 1'b0;
			err_d_r  <= 1'b0;
		end else begin
			cc_r     <= !err;
			attach_r <= attach;
			f3_r     <= flag_3a;
			f15_r    <= flag_1a5;
			aux_r    <= aux_nxt;
			orient_r <= attach && STATUS.cc2_side;
			pp_r     <= pp_nxt;
			err_d_r  <= err;
		end
	end

	// ============================================================
	// Discharge: one timer drives both paths, so they cannot drift apart.
	wire        err_entry   = err && !err_d_r;
	wire        drain_start = NVM_CFG.drain_en && (STATUS.detach || err_entry);
	wire        ov_detach   = STATUS.detach && err;
	wire  [3:0] drain_len   = ov_detach ? OV_TICKS : NVM_CFG.drain_ticks;
	logic       drain_act;

	tcs_drain_timer #(
		.TICK_CYCLES (TICK_CYCLES)
	) tcs_drain_timer_inst (
		.clk    (SYS_CLK),
		.reset  (RESET),
		.start  (drain_start),
		.ticks  (drain_len),
		.active (drain_act)
	);

	assign REG_RDATA                     = rdata_r;
	assign CC1_TERM_EN                   = cc_r;
	assign CC2_TERM_EN                   = cc_r;
	assign ATTACH_PULL                   = attach_r;
	assign HIGH_CURRENT_FLAG_N_PULL      = f3_r;
	assign MEDIUM_CURRENT_FLAG_N_PULL    = f15_r;
	assign AUX_OUT_PULL                  = aux_r;
	assign ORIENT_PULL                   = orient_r;
	assign POWER_PATH_ENABLE_N_PULL      = pp_r;
	assign SYSTEM_DISCHARGE_N_PULL       = drain_act;
	assign RECEPTACLE_SENSE_DISCHARGE_EN = drain_act;

	// ============================================================
	// Checks.
	chk_cc_reset_off: assert property (@(posedge SYS_CLK)
		RESET |=> !CC1_TERM_EN && !CC2_TERM_EN)
		else $error("CC termination on during reset");
	chk_attach_source: assert property (@(posedge SYS_CLK) disable iff (RESET)
		STATUS.src_attached && !err |=> ATTACH_PULL)
		else $error("attach not pulled for source");
	chk_attach_debug: assert property (@(posedge SYS_CLK) disable iff (RESET)
		STATUS.debug_attached && !err |=> ATTACH_PULL)
		else $error("attach not pulled for debug accessory");
	chk_flag_high: assert property (@(posedge SYS_CLK) disable iff (RESET)
		##1 HIGH_CURRENT_FLAG_N_PULL == $past(STATUS.src_attached && STATUS.adv_3a && !err))
		else $error("high current flag wrong");
	chk_flag_medium: assert property (@(posedge SYS_CLK) disable iff (RESET)
		##1 MEDIUM_CURRENT_FLAG_N_PULL == $past(STATUS.src_attached && STATUS.adv_1a5 && !err))
		else $error("medium current flag wrong");
	chk_aux_software: assert property (@(posedge SYS_CLK) disable iff (RESET)
		NVM_CFG.gpio_cfg == tcs_pkg::TCS_GPIO_SOFTWARE ##1 $stable(NVM_CFG.gpio_cfg)
		|-> AUX_OUT_PULL == $past(aux_out_software_r[0]))
		else $error("aux does not follow software bit");
	chk_aux_fault: assert property (@(posedge SYS_CLK) disable iff (RESET)
		NVM_CFG.gpio_cfg == tcs_pkg::TCS_GPIO_FAULT && (hw_fault || err) |=> AUX_OUT_PULL)
		else $error("aux not pulled on fault");
	chk_aux_debug: assert property (@(posedge SYS_CLK) disable iff (RESET)
		NVM_CFG.gpio_cfg == tcs_pkg::TCS_GPIO_DEBUG && !STATUS.debug_attached
		|=> !AUX_OUT_PULL)
		else $error("aux pulled without debug accessory");
	chk_aux_sink: assert property (@(posedge SYS_CLK) disable iff (RESET)
		NVM_CFG.gpio_cfg == tcs_pkg::TCS_GPIO_SINK_POWER
		|=> AUX_OUT_PULL == HIGH_CURRENT_FLAG_N_PULL)
		else $error("aux differs from high current flag");
	chk_orient_cc1: assert property (@(posedge SYS_CLK) disable iff (RESET)
		!STATUS.cc2_side |=> !ORIENT_PULL)
		else $error("orientation pulled for CC1");
	chk_orient_cc2: assert property (@(posedge SYS_CLK) disable iff (RESET)
		attach && STATUS.cc2_side |=> ORIENT_PULL)
		else $error("orientation not pulled for CC2");
	chk_drain_together: assert property (@(posedge SYS_CLK)
		SYSTEM_DISCHARGE_N_PULL == RECEPTACLE_SENSE_DISCHARGE_EN)
		else $error("discharge paths differ");
	chk_drain_start: assert property (@(posedge SYS_CLK) disable iff (RESET)
		drain_start |=> SYSTEM_DISCHARGE_N_PULL)
		else $error("discharge did not start");
	chk_pp_window: assert property (@(posedge SYS_CLK) disable iff (RESET)
		vbus_high_ov || !vbus_low_ok |=> !POWER_PATH_ENABLE_N_PULL)
		else $error("power path on outside VBUS window");
	chk_pp_enable: assert property (@(posedge SYS_CLK) disable iff (RESET)
		src_ok && vbus_ok |=> POWER_PATH_ENABLE_N_PULL)
		else $error("power path not enabled");
	chk_err_release: assert property (@(posedge SYS_CLK) disable iff (RESET)
		err |=> !POWER_PATH_ENABLE_N_PULL && !HIGH_CURRENT_FLAG_N_PULL
		&& !MEDIUM_CURRENT_FLAG_N_PULL && !CC1_TERM_EN)
		else $error("error recovery left outputs on");
	chk_ov_drain: assert property (@(posedge SYS_CLK) disable iff (RESET)
		ov_detach && NVM_CFG.drain_en |=> SYSTEM_DISCHARGE_N_PULL [*2])
		else $error("overvoltage discharge too short");
	chk_reset_release: assert property (@(posedge SYS_CLK)
		RESET |=> !ATTACH_PULL && !AUX_OUT_PULL && !POWER_PATH_ENABLE_N_PULL
		&& aux_out_software_r == 8'h00)
		else $error("output active during reset");

	// Main scenarios that the tests are meant to reach.
	cov_source_3a: cover property (@(posedge SYS_CLK) disable iff (RESET)
		HIGH_CURRENT_FLAG_N_PULL && POWER_PATH_ENABLE_N_PULL);
	cov_err_drain: cover property (@(posedge SYS_CLK) disable iff (RESET)
		err_entry ##1 SYSTEM_DISCHARGE_N_PULL);
	cov_sw_aux: cover property (@(posedge SYS_CLK) disable iff (RESET)
		NVM_CFG.gpio_cfg == tcs_pkg::TCS_GPIO_SOFTWARE && AUX_OUT_PULL);
	cov_debug_aux: cover property (@(posedge SYS_CLK) disable iff (RESET)
		NVM_CFG.gpio_cfg == tcs_pkg::TCS_GPIO_DEBUG && AUX_OUT_PULL);

endmodule // tcs_status_outputs

// [tcs_defs.svh]
`ifndef TCS_DEFS_SVH
`define TCS_DEFS_SVH

// ============================================================
// Register map
`define TCS_REG_GPIO_SW       8'h2D
`define TCS_GPIO_SW_BIT       0
`define TCS_GPIO_SW_RST       8'h00

// ============================================================
// Timing
`define TCS_CLK_PERIOD_NS     10
`define TCS_DRAIN_TICK_US     1000
`define TCS_DRAIN_TICK_CYCLES ((`TCS_DRAIN_TICK_US * 1000) / `TCS_CLK_PERIOD_NS)
`define TCS_OV_DRAIN_TICKS    4'h4

`endif

// [tcs_pkg.sv]
package tcs_pkg;

	// ============================================================
	// Function of the general-purpose output.
	typedef enum logic [1:0] {
		TCS_GPIO_SOFTWARE   = 2'h0,
		TCS_GPIO_FAULT      = 2'h1,
		TCS_GPIO_DEBUG      = 2'h2,
		TCS_GPIO_SINK_POWER = 2'h3
	} tcs_gpio_mode_e;

	// ============================================================
	// Port status from the Type-C state machine, same clock.
	typedef struct packed {
		logic src_attached;
		logic debug_attached;
		logic cc2_side;
		logic adv_3a;
		logic adv_1a5;
		logic err_recovery;
		logic detach;
	} tcs_status_s;

	// ============================================================
	// Non-volatile settings, static after load.
	typedef struct packed {
		tcs_gpio_mode_e gpio_cfg;
		logic           drain_en;
		logic [3:0]     drain_ticks;
	} tcs_nvm_s;

endpackage

// [tcs_system_discharge_n_timer.sv]
`timescale 1ns/10ps
`include "tcs_defs.svh"

// ============================================================
// Discharge timer: counts whole ticks once started.
module tcs_drain_timer #(
	parameter int TICK_CYCLES = `TCS_DRAIN_TICK_CYCLES
) (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       start,
	input  wire logic [3:0] ticks,
	output logic            active
);
	localparam int PW = $clog2(TICK_CYCLES + 1);

	// ============================================================
	// The assertions on the outputs need at least two cycles per tick.
	if (TICK_CYCLES < 2) begin : g_chk
		$error("TICK_CYCLES must be at least 2");
	end

	logic [PW-1:0] pre_r;
	logic [3:0]    left_r;
	logic          active_r;
	wire           tick_end = (pre_r == PW'(TICK_CYCLES - 1));
	wire  [3:0]    load     = (ticks == 4'h0) ? 4'h1 : ticks;

	// A zero setting still gives one tick, so a start is never lost.
	always_ff @(posedge clk) begin
		if (reset) begin
			pre_r    <= '0;
			left_r   <= 4'h0;
			active_r <= 1'b0;
		end else if (start) begin
			pre_r    <= '0;
			left_r   <= load;
			active_r <= 1'b1;
		end else if (active_r) begin
			pre_r    <= tick_end ? '0 : pre_r + PW'(1);
			left_r   <= tick_end ? left_r - 4'h1 : left_r;
			active_r <= !(tick_end && left_r == 4'h1);
		end
	end

	assign active = active_r;

endmodule // tcs_drain_timer

// [tcs_source_model.sv]
`timescale 1ns/10ps

// ============================================================
// Source or debug accessory on the far side, seen as port status.
module tcs_source_model (
	input  wire logic            clk,
	input  wire logic            plug,
	input  wire logic            dbg,
	input  wire logic            flip,
	input  wire logic [1:0]      adv,
	input  wire logic            err,
	output wire tcs_pkg::tcs_status_s status,
	output logic                 vbus_ok
);
	logic plug_r;

	// The old plug level turns an unplug into a single-cycle detach pulse.
	always_ff @(posedge clk) begin
		plug_r <= plug;
	end

	// A level is advertised only while a real source is plugged in.
	assign status.src_attached   = plug & ~dbg;
	assign status.debug_attached = plug & dbg;
	assign status.cc2_side       = plug & flip;
	assign status.adv_3a         = status.src_attached & (adv == 2'h2);
	assign status.adv_1a5        = status.src_attached & (adv == 2'h1);
	assign status.err_recovery   = err;
	assign status.detach         = plug_r & ~plug;
	assign vbus_ok               = plug;
endmodule // tcs_source_model

// [typec_sink_status_outputs_bench.sv]
`timescale 1ns/10ps

module typec_sink_status_outputs_bench;
	localparam int         TICKS_CYC = 4;
	localparam logic [3:0] OV        = 4'h3;
	logic                  SYS_CLK, RESET, plug, dbg, flip, err, high_v, fault, reg_wr;
	logic                  vbus_ok, disc_sys, disc_rcp;
	logic [1:0]            adv;
	logic [7:0]            reg_addr, reg_wdata, rdata, sw;
	wire  [7:0]            outs;
	tcs_pkg::tcs_nvm_s     nvm;
	tcs_pkg::tcs_status_s  status;
	int                    fail_count, cmp_count, cyc, n, m, ex;

	tcs_source_model tcs_source_model_inst (.clk(SYS_CLK), .plug(plug), .dbg(dbg),
		.flip(flip), .adv(adv), .err(err), .status(status), .vbus_ok(vbus_ok));

	tcs_status_outputs #(.TICK_CYCLES(TICKS_CYC), .OV_TICKS(OV)) tcs_status_outputs_inst (
		.SYS_CLK(SYS_CLK), .RESET(RESET), .STATUS(status), .NVM_CFG(nvm),
		.VBUS_ABOVE_LOW(vbus_ok), .VBUS_ABOVE_HIGH(high_v), .HW_FAULT(fault),
		.REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_WDATA(reg_wdata), .REG_RDATA(rdata),
		.CC1_TERM_EN(outs[1]), .CC2_TERM_EN(outs[0]), .ATTACH_PULL(outs[7]),
		.HIGH_CURRENT_FLAG_N_PULL(outs[6]), .MEDIUM_CURRENT_FLAG_N_PULL(outs[5]),
		.AUX_OUT_PULL(outs[4]), .ORIENT_PULL(outs[3]), .POWER_PATH_ENABLE_N_PULL(outs[2]),
		.SYSTEM_DISCHARGE_N_PULL(disc_sys), .RECEPTACLE_SENSE_DISCHARGE_EN(disc_rcp));

	// ============================================================
	// Expected pull-low enables for the present stimulus.
	function automatic logic [7:0] exp_outs();
		logic src, hi, aux;
		src = plug & ~dbg & ~err;
		hi  = src & (adv == 2'h2);
		case (nvm.gpio_cfg)
			tcs_pkg::TCS_GPIO_SOFTWARE: aux = sw[0];
			tcs_pkg::TCS_GPIO_FAULT:    aux = fault | err;
			tcs_pkg::TCS_GPIO_DEBUG:    aux = plug & dbg;
			default:                    aux = hi;
		endcase
		return {plug & ~err, hi, src & (adv == 2'h1), aux, plug & ~err & flip,
			src & ~high_v, ~err, ~err};
	endfunction

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	// Register access: one write strobe, then a read one cycle after the address.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge SYS_CLK);
		reg_wr = 1'b0;
		if (a == 8'h2D)
			sw = d;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		reg_addr = a;
		@(negedge SYS_CLK);
		chk("read data", e, rdata);
	endtask

	task automatic do_reset(input int cycles);
		RESET = 1'b1;
		repeat (cycles) @(negedge SYS_CLK);
		chk("outputs in reset", 8'h00, outs);
		chk("discharge in reset", 8'h00, {6'h00, disc_sys, disc_rcp});
		RESET = 1'b0;
		sw = 8'h00;
	endtask

	task automatic summarize();
		$display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Free-running clock; the ceiling is well above the few hundred cycles needed.
	initial begin
		SYS_CLK = 1'b0;
		forever #5 SYS_CLK = ~SYS_CLK;
	end

	always @(posedge SYS_CLK) begin
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			summarize();
		end
	end

	// ============================================================
	// Main sequence.
	initial begin
		{plug, dbg, flip, err, high_v, fault, reg_wr, adv} = 9'h000;
		{reg_addr, reg_wdata, sw} = 24'h000000;
		nvm = {tcs_pkg::TCS_GPIO_SINK_POWER, 1'b1, 4'h2};
		void'($urandom(32'h51B6));
		do_reset(8);
		wr(8'h2D, 8'($urandom));
		rd(8'h2D, sw);
		wr(8'h2C, 8'hA5);
		rd(8'h2D, sw);
		rd(8'h2C, 8'h00);
		$display("register test done");
		// Every aux mode in turn, with random attach, level, side and faults.
		for (int i = 0; i < 64; i++) begin
			nvm.gpio_cfg = tcs_pkg::tcs_gpio_mode_e'(i[1:0]);
			plug = 1'($urandom);
			dbg = ($urandom % 4 == 0);
			flip = 1'($urandom);
			adv = 2'($urandom % 3);
			err = ($urandom % 8 == 0);
			high_v = ($urandom % 8 == 0);
			fault = 1'($urandom);
			if ($urandom % 2)
				wr(8'h2D, 8'($urandom));
			repeat (5) @(negedge SYS_CLK);
			chk("status outputs", exp_outs(), outs);
		end
		$display("status test done");
		// Discharge off, normal length, then detach during error recovery.
		for (int k = 0; k < 3; k++) begin
			nvm.drain_en = (k != 0);
			{plug, dbg, err, high_v} = 4'h8;
			repeat (20) @(negedge SYS_CLK);
			if (k == 2) begin
				err = 1'b1;
				repeat (12) @(negedge SYS_CLK);
			end
			plug = 1'b0;
			n = 0;
			m = 0;
			repeat (20) begin
				@(negedge SYS_CLK);
				n += (disc_sys === 1'b1 && disc_rcp === 1'b1);
				m += (disc_sys === 1'b1 || disc_rcp === 1'b1);
			end
			ex = (k == 0) ? 0 : ((k == 1) ? int'(nvm.drain_ticks) : int'(OV)) * TICKS_CYC;
			chk("discharge cycles", 8'(ex), 8'(n));
			chk("discharge either", 8'(ex), 8'(m));
		end
		$display("discharge test done");
		err = 1'b0;
		wr(8'h2D, 8'hFF);
		do_reset(2);
		rd(8'h2D, 8'h00);
		$display("second reset test done");
		summarize();
	end
endmodule // typec_sink_status_outputs_bench
